// [core/ite_engine.sv]
// Interrupt-activated transfer engine with bus slave and master
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ite_defines.svh"
module ite_engine
  import ite_pkg::*;
#(
  parameter int NCH = 32,
  parameter int CW = 5
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [NCH-1:0] act_req,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic m_cyc_o,
  output logic m_stb_o,
  output logic m_we_o,
  output logic [31:0] m_adr_o,
  output logic [3:0] m_sel_o,
  output logic [31:0] m_dat_o,
  input wire logic [31:0] m_dat_i,
  input wire logic m_ack_i,
  output logic [NCH-1:0] irq_o,
  output logic elc_o,
  output logic [CW-1:0] elc_ch_o
);
  // Software-visible state
  logic [31:0] ctrl_r; // Module stop, read skip, short address
  logic [31:0] base_r; // Start of the information table
  logic [NCH-1:0] pend_r; // Accepted but not yet serviced
  logic [NCH-1:0] stop_r; // Exhausted normal-mode channels
  // Sequencer state
  ite_state_t st_r;
  logic [CW-1:0] ch_r; // Channel being serviced
  logic [31:0] info_r; // Address of the current record
  logic [1:0] iw_r; // Record word index
  logic [31:0] mode_r;
  logic [31:0] sar_r;
  logic [31:0] dar_r;
  logic [31:0] cnt_r;
  logic [31:0] dat_r; // Unit held between read and write
  logic done_r; // Programmed volume finished
  logic chained_r; // Current record came from a chain
  logic [CW-1:0] last_ch_r;
  logic last_ok_r; // Cached record is reusable

  // ---------------- Peripheral bus slave ----------------
  logic wb_req;
  logic wb_wr;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [31:0] stat_w;
  logic [NCH-1:0] stop_w1c;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Busy in bit 0, current channel from bit 7 upward, the rest reads zero
  assign stat_w = {20'h00000, CW'(ch_r), 7'(st_r != ITE_S_IDLE)};
  // Address decode; unmapped offsets read zero and are acked
  assign rd_mux = (wb_adr_i == `ITE_OFS_CTRL) ? ctrl_r :
                  (wb_adr_i == `ITE_OFS_BASE) ? base_r :
                  (wb_adr_i == `ITE_OFS_STAT) ? stat_w :
                  (wb_adr_i == `ITE_OFS_STOP) ? 32'(stop_r) :
                  (wb_adr_i == `ITE_OFS_PEND) ? 32'(pend_r) : 32'h0000_0000;
  // Write one to clear an exhausted channel
  assign stop_w1c = (wb_wr && wb_adr_i == `ITE_OFS_STOP) ? NCH'(wb_dat_i & wmask) : '0;

  // Single-cycle acknowledge, dropped the cycle after
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_r <= `ITE_CTRL_RST;
      base_r <= `ITE_BASE_RST;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
      if (wb_wr && wb_adr_i == `ITE_OFS_CTRL) begin
        ctrl_r <= ((ctrl_r & ~wmask) | (wb_dat_i & wmask)) & 32'h0000_0007;
      end
      if (wb_wr && wb_adr_i == `ITE_OFS_BASE) begin
        base_r <= ((base_r & ~wmask) | (wb_dat_i & wmask)) & 32'hFFFF_FFFC;
      end
    end
  end

  // ---------------- Channel selection ----------------
  logic pick_vld;
  logic [CW-1:0] pick_idx;
  logic take;
  logic [NCH-1:0] one_hot;
  logic [NCH-1:0] stop_set;
  // Lowest pending channel is serviced first
  ite_prio #(.N(NCH), .W(CW)) u_prio (
    .req(pend_r),
    .vld(pick_vld),
    .idx(pick_idx)
  );
  // Module stop freezes acceptance; pending requests are kept
  assign take = (st_r == ITE_S_IDLE) & pick_vld & ~ctrl_r[`ITE_CTRL_MSTP];
  assign one_hot = {{(NCH-1){1'b0}}, 1'b1} << pick_idx;

  // ---------------- Transfer arithmetic ----------------
  logic [1:0] md;
  logic [1:0] sz;
  logic [1:0] sm;
  logic [1:0] dm;
  logic [31:0] unit;
  logic [31:0] sar_s;
  logic [31:0] dar_s;
  logic [15:0] ncnt_n;
  logic [7:0] ctr_n;
  logic [15:0] bcnt_n;
  logic wrap;
  logic [8:0] rep_n;
  logic [31:0] span;
  logic [31:0] sar_n;
  logic [31:0] dar_n;
  logic [31:0] cnt_n;
  logic unit_end;
  logic total_end;
  logic chain;
  assign md = mode_r[`ITE_F_MD];
  assign sz = mode_r[`ITE_F_SZ];
  assign sm = mode_r[`ITE_F_SM];
  assign dm = mode_r[`ITE_F_DM];
  // Unit width 1, 2 or 4 bytes
  assign unit = (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
  // Bit 0 moves the address, bit 1 turns the step downward
  assign sar_s = !sm[0] ? sar_r : sm[1] ? sar_r - unit : sar_r + unit;
  assign dar_s = !dm[0] ? dar_r : dm[1] ? dar_r - unit : dar_r + unit;
  assign ncnt_n = cnt_r[`ITE_F_NCNT] - 16'h0001;
  assign ctr_n = cnt_r[`ITE_F_CTR] - 8'h01;
  assign bcnt_n = cnt_r[`ITE_F_BCNT] - 16'h0001;
  assign wrap = (ctr_n == 8'h00);
  // A reload of zero stands for 256 units
  assign rep_n = (cnt_r[`ITE_F_RELOAD] == 8'h00) ? 9'h100 : {1'b0, cnt_r[`ITE_F_RELOAD]};
  assign span = 32'(rep_n) << sz;
  // Repeat-side address returns to where the area started
  always_comb begin
    sar_n = sar_s;
    dar_n = dar_s;
    if (md != `ITE_MD_NORMAL && wrap) begin
      if (mode_r[`ITE_F_DTS]) begin
        sar_n = sm[1] ? sar_s + span : sar_s - span;
      end else begin
        dar_n = dm[1] ? dar_s + span : dar_s - span;
      end
    end
  end
  // Count update and end of activation per mode
  always_comb begin
    cnt_n = cnt_r;
    unit_end = 1'b1;
    total_end = 1'b0;
    if (md == `ITE_MD_REPEAT) begin
      cnt_n[`ITE_F_CTR] = wrap ? cnt_r[`ITE_F_RELOAD] : ctr_n;
    end else if (md == `ITE_MD_BLOCK) begin
      cnt_n[`ITE_F_CTR] = wrap ? cnt_r[`ITE_F_RELOAD] : ctr_n;
      cnt_n[`ITE_F_BCNT] = wrap ? bcnt_n : cnt_r[`ITE_F_BCNT];
      unit_end = wrap;
      total_end = wrap && (bcnt_n == 16'h0000);
    end else begin
      cnt_n[`ITE_F_NCNT] = ncnt_n;
      total_end = (ncnt_n == 16'h0000);
    end
  end
  // Chain on every record or only when the count ran out
  assign chain = mode_r[`ITE_F_CHNE] & (~mode_r[`ITE_F_CHNS] | done_r);
  // Exhausted normal channel stops being serviced unless its record chains
  assign stop_set = (st_r == ITE_S_END && !chain && md == `ITE_MD_NORMAL && done_r) ?
                    ({{(NCH-1){1'b0}}, 1'b1} << ch_r) : '0;

  // Hardware set wins over clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= '0;
      stop_r <= '0;
    end else begin
      pend_r <= (pend_r & ~(take ? one_hot : '0)) | act_req;
      stop_r <= (stop_r & ~stop_w1c) | stop_set;
    end
  end

  // ---------------- Address forms and lanes ----------------
  logic [31:0] src_a;
  logic [31:0] dst_a;
  logic [31:0] rd_val;
  logic [31:0] wr_dat;
  logic [3:0] rd_sel;
  logic [3:0] wr_sel;
  logic [31:0] wb_val;
  logic wb_need;
  // Short mode sign-extends 24 bits to both ends of the map
  assign src_a = ctrl_r[`ITE_CTRL_SAM] ? {{8{sar_r[23]}}, sar_r[23:0]} : sar_r;
  assign dst_a = ctrl_r[`ITE_CTRL_SAM] ? {{8{dar_r[23]}}, dar_r[23:0]} : dar_r;
  ite_lane u_src (
    .sz(sz),
    .ofs(src_a[1:0]),
    .rdata(m_dat_i),
    .wval(32'h0000_0000),
    .rval(rd_val),
    .wdata(),
    .sel(rd_sel)
  );
  ite_lane u_dst (
    .sz(sz),
    .ofs(dst_a[1:0]),
    .rdata(32'h0000_0000),
    .wval(dat_r),
    .rval(),
    .wdata(wr_dat),
    .sel(wr_sel)
  );
  // Fixed addresses are not written back
  assign wb_need = (iw_r == `ITE_IW_SRC && sm[0]) || (iw_r == `ITE_IW_DST && dm[0]) ||
                   (iw_r == `ITE_IW_CNT);
  assign wb_val = (iw_r == `ITE_IW_SRC) ? sar_r : (iw_r == `ITE_IW_DST) ? dar_r : cnt_r;

  // ---------------- Sequencer and bus master ----------------
  // Each access holds cyc until ack, then idles one cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ITE_S_IDLE;
      ch_r <= '0;
      info_r <= 32'h0000_0000;
      iw_r <= 2'h0;
      mode_r <= 32'h0000_0000;
      sar_r <= 32'h0000_0000;
      dar_r <= 32'h0000_0000;
      cnt_r <= 32'h0000_0000;
      dat_r <= 32'h0000_0000;
      done_r <= 1'b0;
      chained_r <= 1'b0;
      last_ch_r <= '0;
      last_ok_r <= 1'b0;
      m_cyc_o <= 1'b0;
      m_stb_o <= 1'b0;
      m_we_o <= 1'b0;
      m_adr_o <= 32'h0000_0000;
      m_sel_o <= 4'h0;
      m_dat_o <= 32'h0000_0000;
      irq_o <= '0;
      elc_o <= 1'b0;
      elc_ch_o <= '0;
    end else begin
      irq_o <= '0;
      elc_o <= 1'b0;
      // Table moves between activations make the cached record stale
      if (wb_wr && wb_adr_i == `ITE_OFS_BASE) begin
        last_ok_r <= 1'b0;
      end
      case (st_r)
        ITE_S_IDLE: begin
          if (take && stop_r[pick_idx]) begin
            irq_o <= one_hot;
          end else if (take) begin
            ch_r <= pick_idx;
            info_r <= base_r + ({{(32-CW){1'b0}}, pick_idx} << 4);
            chained_r <= 1'b0;
            done_r <= 1'b0;
            iw_r <= `ITE_IW_MODE;
            // Same channel again: reuse the held record
            if (ctrl_r[`ITE_CTRL_RRS] && last_ok_r && last_ch_r == pick_idx) begin
              st_r <= ITE_S_RD;
            end else begin
              st_r <= ITE_S_INFO;
            end
          end
        end
        ITE_S_INFO: begin
          if (!m_cyc_o) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o <= 1'b0;
            m_adr_o <= info_r + {28'h0000000, iw_r, 2'b00};
            m_sel_o <= 4'hF;
          end else if (m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            if (iw_r == `ITE_IW_MODE) mode_r <= m_dat_i;
            if (iw_r == `ITE_IW_SRC) sar_r <= m_dat_i;
            if (iw_r == `ITE_IW_DST) dar_r <= m_dat_i;
            if (iw_r == `ITE_IW_CNT) begin
              cnt_r <= m_dat_i;
              st_r <= ITE_S_RD;
            end
            iw_r <= iw_r + 2'h1;
          end
        end
        ITE_S_RD: begin
          if (!m_cyc_o) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o <= 1'b0;
            m_adr_o <= {src_a[31:2], 2'b00};
            m_sel_o <= rd_sel;
          end else if (m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            dat_r <= rd_val;
            st_r <= ITE_S_WR;
          end
        end
        ITE_S_WR: begin
          if (!m_cyc_o) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o <= 1'b1;
            m_adr_o <= {dst_a[31:2], 2'b00};
            m_sel_o <= wr_sel;
            m_dat_o <= wr_dat;
          end else if (m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            m_we_o <= 1'b0;
            sar_r <= sar_n;
            dar_r <= dar_n;
            cnt_r <= cnt_n;
            // Event per unit, or per whole block
            elc_o <= unit_end;
            elc_ch_o <= ch_r;
            if (unit_end) begin
              done_r <= total_end;
              iw_r <= `ITE_IW_SRC;
              st_r <= ITE_S_WB;
            end else begin
              st_r <= ITE_S_RD;
            end
          end
        end
        ITE_S_WB: begin
          if (!wb_need) begin
            iw_r <= iw_r + 2'h1;
          end else if (!m_cyc_o) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o <= 1'b1;
            m_adr_o <= info_r + {28'h0000000, iw_r, 2'b00};
            m_sel_o <= 4'hF;
            m_dat_o <= wb_val;
          end else if (m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            m_we_o <= 1'b0;
            iw_r <= iw_r + 2'h1;
            if (iw_r == `ITE_IW_CNT) st_r <= ITE_S_END;
          end
        end
        ITE_S_END: begin
          // Per-transfer or end-of-volume CPU interrupt
          if (mode_r[`ITE_F_DISEL] || done_r) begin
            irq_o <= {{(NCH-1){1'b0}}, 1'b1} << ch_r;
          end
          if (chain) begin
            info_r <= info_r + `ITE_INFO_STRIDE;
            iw_r <= `ITE_IW_MODE;
            chained_r <= 1'b1;
            done_r <= 1'b0;
            st_r <= ITE_S_INFO;
          end else begin
            last_ch_r <= ch_r;
            last_ok_r <= ~chained_r;
            st_r <= ITE_S_IDLE;
          end
        end
        default: st_r <= ITE_S_IDLE;
      endcase
    end
  end
endmodule // ite_engine

// [core/ite_defines.svh]
// Offsets, field positions and reset values of the transfer engine
`ifndef ITE_DEFINES_SVH
`define ITE_DEFINES_SVH
// Register offsets on the peripheral bus (byte addresses)
`define ITE_OFS_CTRL 8'h00
`define ITE_OFS_BASE 8'h04
`define ITE_OFS_STAT 8'h08
`define ITE_OFS_STOP 8'h0C
`define ITE_OFS_PEND 8'h10
// Control register bits
`define ITE_CTRL_MSTP 0
`define ITE_CTRL_RRS 1
`define ITE_CTRL_SAM 2
`define ITE_CTRL_RST 32'h0000_0000
`define ITE_BASE_RST 32'h0000_0000
// Transfer information record: four words per channel
`define ITE_INFO_STRIDE 32'h0000_0010
`define ITE_IW_MODE 2'h0
`define ITE_IW_SRC 2'h1
`define ITE_IW_DST 2'h2
`define ITE_IW_CNT 2'h3
// Fields of the mode word
`define ITE_F_MD 31:30
`define ITE_F_SZ 29:28
`define ITE_F_SM 27:26
`define ITE_F_DM 25:24
`define ITE_F_CHNE 23
`define ITE_F_CHNS 22
`define ITE_F_DISEL 21
`define ITE_F_DTS 20
// Transfer mode codes
`define ITE_MD_NORMAL 2'h0
`define ITE_MD_REPEAT 2'h1
`define ITE_MD_BLOCK 2'h2
// Fields of the count word
`define ITE_F_RELOAD 31:24
`define ITE_F_CTR 23:16
`define ITE_F_NCNT 31:16
`define ITE_F_BCNT 15:0
`endif

// [core/ite_pkg.sv]
// Types shared by the transfer engine modules
package ite_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ITE_S_IDLE,
    ITE_S_INFO,
    ITE_S_RD,
    ITE_S_WR,
    ITE_S_WB,
    ITE_S_END
  } ite_state_t;
endpackage

// [core/ite_prio.sv]
// Fixed-priority picker: lowest pending channel wins
`timescale 1ns/1ps
module ite_prio
  import ite_pkg::*;
#(
  parameter int N = 32,
  parameter int W = 5
) (
  input wire logic [N-1:0] req,
  output logic vld,
  output logic [W-1:0] idx
);
  // Chain from the top so that the lowest index overrides
  logic [W-1:0] pick [N:0];
  assign pick[N] = '0;
  genvar i;
  generate
    for (i = N - 1; i >= 0; i--) begin : g_pick
      assign pick[i] = req[i] ? W'(i) : pick[i+1];
    end
  endgenerate
  assign idx = pick[0];
  assign vld = |req;
endmodule // ite_prio

// [core/ite_lane.sv]
// Byte-lane steering for byte, word and longword units
`timescale 1ns/1ps
module ite_lane
  import ite_pkg::*;
(
  input wire logic [1:0] sz,
  input wire logic [1:0] ofs,
  input wire logic [31:0] rdata,
  input wire logic [31:0] wval,
  output logic [31:0] rval,
  output logic [31:0] wdata,
  output logic [3:0] sel
);
  // Little-endian lane shift from the low address bits
  logic [4:0] sh;
  logic [31:0] rsh;
  logic [3:0] mask;
  assign sh = {ofs, 3'b000};
  assign rsh = rdata >> sh;
  // Unit width mask before alignment
  assign mask = (sz == 2'h0) ? 4'h1 : (sz == 2'h1) ? 4'h3 : 4'hF;
  assign sel = mask << ofs;
  // Read value is right-aligned and zero-filled
  assign rval = (sz == 2'h0) ? {24'h000000, rsh[7:0]} :
                (sz == 2'h1) ? {16'h0000, rsh[15:0]} : rsh;
  assign wdata = wval << sh;
endmodule // ite_lane

// [verif/ite_mem_model.sv]
// Main bus memory slave answering after a programmable delay
`timescale 1ns/1ps
module ite_mem_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] dly,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [31:0] adr,
  input wire logic [3:0] sel,
  input wire logic [31:0] wdat,
  output logic [31:0] rdat,
  output logic ack
);
  logic [31:0] mem [256]; // 1 KB window; upper address bits alias
  logic [3:0] wait_r; // Cycles the current request has waited
  // Answer after dly cycles, byte lanes from sel
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      wait_r <= 4'h0;
      rdat <= 32'h0;
    end else if (cyc && stb && !ack && wait_r >= dly) begin
      ack <= 1'b1;
      wait_r <= 4'h0;
      rdat <= mem[adr[9:2]];
      for (int i = 0; i < 4; i++) if (we && sel[i]) mem[adr[9:2]][8*i+:8] <= wdat[8*i+:8];
    end else begin
      // Data toggles while idle so stale values never look valid
      ack <= 1'b0;
      rdat <= ~rdat;
      if (cyc && stb && !ack) wait_r <= wait_r + 4'h1;
    end
  end
endmodule // ite_mem_model

// [verif/ite_engine_sva.sv]
// Port-level assertions for the transfer engine
`timescale 1ns/1ps
module ite_engine_chk
  import ite_pkg::*;
#(
  parameter int NCH = 32,
  parameter int CW = 5
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic m_cyc_o,
  input wire logic m_stb_o,
  input wire logic m_we_o,
  input wire logic [31:0] m_adr_o,
  input wire logic [3:0] m_sel_o,
  input wire logic [31:0] m_dat_o,
  input wire logic m_ack_i,
  input wire logic [NCH-1:0] irq_o,
  input wire logic elc_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic wr_ack; // Write accepted on the main bus
  assign wr_ack = m_cyc_o && m_we_o && m_ack_i;
  sequence s_wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_m_wait;
    m_cyc_o && m_stb_o && !m_ack_i;
  endsequence
  a_wb_ack_next: assert property (s_wb_take |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  a_wb_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_m_req_hold: assert property (s_m_wait |=> m_cyc_o && m_stb_o && $stable(m_adr_o)
    && $stable(m_we_o) && $stable(m_sel_o) && $stable(m_dat_o))
    else $error("main bus request changed before ack");
  a_m_gap_after: assert property (m_cyc_o && m_ack_i |=> !m_cyc_o && !m_stb_o)
    else $error("no idle cycle after main bus ack");
  a_m_lane_sel: assert property (m_cyc_o && m_stb_o |-> m_sel_o != 4'h0 && m_adr_o[1:0] == 2'h0)
    else $error("bad lanes or unaligned address");
  a_elc_pulse: assert property (elc_o |=> !elc_o)
    else $error("event pulse too long");
  a_elc_cause: assert property (elc_o |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("event without preceding write");
  a_irq_pulse: assert property ((irq_o & $past(irq_o)) == '0)
    else $error("interrupt pulse too long");
endmodule // ite_engine_chk
bind ite_engine ite_engine_chk #(.NCH(NCH), .CW(CW)) ite_engine_chk_inst (.clock(clock), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .m_cyc_o(m_cyc_o),
  .m_stb_o(m_stb_o), .m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_sel_o(m_sel_o), .m_dat_o(m_dat_o),
  .m_ack_i(m_ack_i), .irq_o(irq_o), .elc_o(elc_o));

// [verif/test_ite_engine.sv]
// Self-checking bench for the transfer engine
`timescale 1ns/1ps
module test_ite_engine;
  import ite_pkg::*;
  logic clock, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, m_cyc_o, m_stb_o, m_we_o, m_ack_i, elc_o;
  logic [31:0] act_req, wb_dat_i, wb_dat_o, m_adr_o, m_dat_o, m_dat_i, irq_o, irq_acc, q;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, m_sel_o, dly;
  logic [4:0] elc_ch_o;
  int bad_count, checks, nacc, nwr, nelc; // Verdict and bus activity counters
  ite_engine ite_engine_inst (.clock(clock), .arst_n(arst_n), .act_req(act_req), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o), .m_we_o(m_we_o),
    .m_adr_o(m_adr_o), .m_sel_o(m_sel_o), .m_dat_o(m_dat_o), .m_dat_i(m_dat_i), .m_ack_i(m_ack_i),
    .irq_o(irq_o), .elc_o(elc_o), .elc_ch_o(elc_ch_o));
  ite_mem_model ite_mem_model_inst (.clock(clock), .arst_n(arst_n), .dly(dly), .cyc(m_cyc_o),
    .stb(m_stb_o), .we(m_we_o), .adr(m_adr_o), .sel(m_sel_o), .wdat(m_dat_o), .rdat(m_dat_i), .ack(m_ack_i));
  // 40 MHz clock
  always #12.5 clock = ~clock;
  // Count accepted main bus accesses, events and interrupts
  always @(posedge clock) begin
    if (m_cyc_o && m_ack_i) begin
      nacc++;
      if (m_we_o) nwr++;
    end
    if (elc_o) nelc++;
    irq_acc = irq_acc | irq_o;
  end
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [31:0] mw(input logic [1:0] md, sz, sm, dm, input logic [3:0] f);
    return {md, sz, sm, dm, f, 20'h0};
  endfunction
  function automatic logic [31:0] rd(input logic [31:0] a);
    return ite_mem_model_inst.mem[a[9:2]];
  endfunction
  task automatic memw(input logic [31:0] a, d);
    ite_mem_model_inst.mem[a[9:2]] = d;
  endtask
  // Transfer record of a channel, table base at 0x100
  task automatic rec(input int ch, input logic [31:0] md, s, d, c);
    logic [31:0] a;
    a = 32'h100 + 32'(ch) * 32'h10;
    memw(a, md);
    memw(a + 32'h4, s);
    memw(a + 32'h8, d);
    memw(a + 32'hC, c);
  endtask
  // Wait until the main bus has been idle for 16 cycles, bounded
  task automatic quiet;
    int k;
    int n;
    k = 0;
    n = 0;
    while (k < 16 && n < 3000) begin
      @(posedge clock);
      n++;
      k = (m_cyc_o === 1'b0) ? k + 1 : 0;
    end
  endtask
  task automatic clr;
    nacc = 0;
    nwr = 0;
    nelc = 0;
    irq_acc = 32'h0;
  endtask
  // One activation pulse on a source, then wait for completion
  task automatic go(input int ch);
    clr;
    act_req[ch] <= 1'b1;
    @(posedge clock);
    act_req <= 32'h0;
    quiet;
  endtask
  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0, q); chk(q, 32'h0);
    wb(1'b0, 8'h04, 32'h0, q); chk(q, 32'h0);
    wb(1'b0, 8'h08, 32'h0, q); chk(q, 32'h0);
    wb(1'b1, 8'h04, 32'h0000_0103, q);
    wb(1'b0, 8'h04, 32'h0, q); chk(q, 32'h0000_0100);
    wb(1'b1, 8'h14, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h14, 32'h0, q); chk(q, 32'h0);
  endtask
  // Normal mode with slow memory: two units then exhausted
  task automatic t_normal;
    dly <= 4'h3;
    rec(3, mw(2'h0, 2'h2, 2'h1, 2'h1, 4'h0), 32'h200, 32'h300, 32'h0002_0000);
    memw(32'h200, 32'hA5A5_1234);
    memw(32'h204, 32'h5A5A_C3C3);
    go(3);
    chk(rd(32'h300), 32'hA5A5_1234);
    chk(nwr, 4); chk(nelc, 1); chk(32'(elc_ch_o), 32'h3);
    chk(rd(32'h13C), 32'h0001_0000); chk(irq_acc, 32'h0);
    go(3);
    chk(rd(32'h304), 32'h5A5A_C3C3); chk(irq_acc, 32'h8);
    go(3);
    chk(nacc, 0); chk(irq_acc, 32'h8);
    wb(1'b0, 8'h0C, 32'h0, q); chk(q, 32'h8);
    wb(1'b1, 8'h0C, 32'h8, q);
    wb(1'b0, 8'h0C, 32'h0, q); chk(q, 32'h0);
    dly <= 4'h0;
  endtask
  // Byte and word units on fixed addresses, no address write-back
  task automatic t_units;
    rec(1, mw(2'h0, 2'h0, 2'h0, 2'h0, 4'h0), 32'h201, 32'h302, 32'h0001_0000);
    rec(8, mw(2'h0, 2'h1, 2'h0, 2'h0, 4'h0), 32'h202, 32'h300, 32'h0001_0000);
    memw(32'h200, 32'h1122_3344);
    memw(32'h300, 32'h0);
    go(1);
    chk(rd(32'h300), 32'h0033_0000); chk(nwr, 2);
    go(8);
    chk(rd(32'h300), 32'h0033_1122);
  endtask
  // Block of four longwords per request, then repeat area reload
  task automatic t_block_rep;
    rec(2, mw(2'h2, 2'h2, 2'h1, 2'h1, 4'h0), 32'h280, 32'h380, 32'h0404_0002);
    for (int i = 0; i < 4; i++) memw(32'h280 + 32'(i) * 32'h4, 32'h10 + 32'(i));
    go(2);
    chk(nelc, 1); chk(rd(32'h38C), 32'h13);
    rec(4, mw(2'h1, 2'h2, 2'h1, 2'h0, 4'h1), 32'h240, 32'h3C0, 32'h0202_0000);
    memw(32'h240, 32'hAA);
    memw(32'h244, 32'hBB);
    for (int i = 0; i < 3; i++) begin
      go(4);
      chk(rd(32'h3C0), (i == 1) ? 32'hBB : 32'hAA);
    end
  endtask
  // Chain always, then chain only at count zero
  task automatic t_chain;
    rec(5, mw(2'h0, 2'h2, 2'h1, 2'h1, 4'h8), 32'h250, 32'h3D0, 32'h0005_0000);
    rec(6, mw(2'h0, 2'h2, 2'h1, 2'h1, 4'h0), 32'h260, 32'h3E0, 32'h0005_0000);
    memw(32'h250, 32'h55);
    memw(32'h260, 32'h66);
    memw(32'h264, 32'h67);
    memw(32'h3E4, 32'h0);
    go(5);
    chk(rd(32'h3D0), 32'h55); chk(rd(32'h3E0), 32'h66); chk(32'(elc_ch_o), 32'h5);
    memw(32'h150, mw(2'h0, 2'h2, 2'h1, 2'h1, 4'hC));
    go(5);
    chk(rd(32'h3E4), 32'h0);
    memw(32'h15C, 32'h0001_0000);
    go(5);
    chk(rd(32'h3E4), 32'h67);
  endtask
  // Module stop holds a request, read skip on its repeat, source irq
  task automatic t_stop_skip;
    rec(7, mw(2'h0, 2'h2, 2'h1, 2'h1, 4'h0), 32'h2C0, 32'h3F0, 32'h0009_0000);
    rec(0, mw(2'h0, 2'h2, 2'h1, 2'h1, 4'h2), 32'h2E0, 32'h3A0, 32'h0005_0000);
    wb(1'b1, 8'h00, 32'h1, q);
    go(7);
    chk(nacc, 0);
    wb(1'b0, 8'h10, 32'h0, q); chk(q, 32'h80);
    clr;
    wb(1'b1, 8'h00, 32'h2, q);
    quiet;
    chk(nacc, 9);
    go(7);
    chk(nacc, 5);
    go(0);
    chk(irq_acc, 32'h1);
  endtask
  // Bound on the whole run
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    give_verdict;
  end
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    act_req = 32'h0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    dly = 4'h0;
    bad_count = 0;
    checks = 0;
    clr;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_regs;
    t_normal;
    t_units;
    t_block_rep;
    t_chain;
    t_stop_skip;
    give_verdict;
  end
endmodule // test_ite_engine
